// ===== rtl/dier_pkg.sv
// constants for the dual interrupt enable routing block
package dier_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int SLOTS  = 12;
  // register offsets
  localparam logic [7:0] OFS_LEVEL0_STATUS     = 8'h05;
  localparam logic [7:0] OFS_LEVEL1_STATUS     = 8'h06;
  localparam logic [7:0] OFS_FIRST_DATA_FIFO   = 8'h14;
  localparam logic [7:0] OFS_SECOND_DATA_FIFO  = 8'h15;
  localparam logic [7:0] OFS_FIRST_LEVEL0      = 8'h16;
  localparam logic [7:0] OFS_FIRST_LEVEL1      = 8'h17;
  // field positions in the data/queue enable registers
  localparam int BIT_QUEUE_THRESHOLD = 15;
  localparam int BIT_QUEUE_UNDERFLOW = 14;
  localparam int BIT_QUEUE_OVERFLOW  = 13;
  localparam int BIT_RESERVED        = 12;
  localparam int SLOT_MSB            = 11;
  // writable bits; everything else reads zero
  localparam logic [15:0] WMASK_DATA_FIFO = 16'hefff;
  localparam logic [15:0] WMASK_LEVEL     = 16'h0fff;
  // reset values
  localparam logic [15:0] RST_ENABLE      = 16'h0000;
  localparam logic [11:0] RST_FLAGS       = 12'h000;
  localparam logic [15:0] READ_UNMAPPED   = 16'h0000;
endpackage

// ===== rtl/dier_level_flags.sv
// sticky per-slot level status flags with write-one-to-clear
`timescale 1ns/1ps
module dier_level_flags (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [11:0] setReq,
  input  wire logic [11:0] clrReq,
  output logic      [11:0] flag_q
);
  // one sticky bit per slot; a set in the clear cycle wins
  for (genvar g = 0; g < dier_pkg::SLOTS; g++) begin : gSlot
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        flag_q[g] <= dier_pkg::RST_FLAGS[g];
      end else if (ce) begin
        if (setReq[g]) begin
          flag_q[g] <= 1'b1;
        end else if (clrReq[g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== rtl/dier_top.sv
// interrupt enable masks routing status flags onto two interrupt lines
`timescale 1ns/1ps
module dier_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [15:0] regRdData,
  input  wire logic        queueThresholdFlag,
  input  wire logic        queueUnderflowFlag,
  input  wire logic        queueOverflowFlag,
  input  wire logic [11:0] slotDataFlag,
  input  wire logic        slotLevelUpdate,
  input  wire logic [11:0] slotLevel0Met,
  input  wire logic [11:0] slotLevel1Met,
  output logic      [11:0] slotLevel0Flag,
  output logic      [11:0] slotLevel1Flag,
  output logic             firstIrq,
  output logic             secondIrq
);

  // register map seen from the strobe port:
  //   0x05 level-0 status, write one to clear bits 11:0
  //   0x06 level-1 status, write one to clear bits 11:0
  //   0x14 first line queue and slot data enables
  //   0x15 second line queue and slot data enables
  //   0x16 first line level-0 enables, bits 11:0
  //   0x17 first line level-1 enables, bits 11:0
  // every other offset ignores writes and reads zero

  // enable registers
  // four masks, each a full sixteen-bit word; the reserved bits are
  // held at zero by the write masks below
  logic [15:0] firstDataFifoEnable_q;   // first output, queue and data
  logic [15:0] secondDataFifoEnable_q;  // second output, queue and data
  logic [15:0] firstLevel0Enable_q;     // first output, level-0
  logic [15:0] firstLevel1Enable_q;     // first output, level-1
  logic [15:0] regRdData_q;             // read data holding register
  logic        firstIrq_q;              // registered first line
  logic        secondIrq_q;             // registered second line

  // address decode; each hit is a full eight-bit compare, so no
  // offset aliases onto another register
  wire hitLevel0Status  = (regAddr == dier_pkg::OFS_LEVEL0_STATUS);
  wire hitLevel1Status  = (regAddr == dier_pkg::OFS_LEVEL1_STATUS);
  wire hitFirstData     = (regAddr == dier_pkg::OFS_FIRST_DATA_FIFO);
  wire hitSecondData    = (regAddr == dier_pkg::OFS_SECOND_DATA_FIFO);
  wire hitFirstLevel0   = (regAddr == dier_pkg::OFS_FIRST_LEVEL0);
  wire hitFirstLevel1   = (regAddr == dier_pkg::OFS_FIRST_LEVEL1);

  // write strobes per register; a strobe seen while ce is low is
  // decoded here, but every flop below ignores it
  wire wrFirstData      = regWrEn & hitFirstData;
  wire wrSecondData     = regWrEn & hitSecondData;
  wire wrFirstLevel0    = regWrEn & hitFirstLevel0;
  wire wrFirstLevel1    = regWrEn & hitFirstLevel1;
  wire wrLevel0Status   = regWrEn & hitLevel0Status;
  wire wrLevel1Status   = regWrEn & hitLevel1Status;

  // masked write values; reserved bits are dropped here
  // bit 12 of the data registers and bits 15:12 of the level
  // registers are never stored, so they always read back as zero
  wire [15:0] dataFifoWr = regWrData & dier_pkg::WMASK_DATA_FIFO;
  wire [15:0] levelWr    = regWrData & dier_pkg::WMASK_LEVEL;

  // level flag set and clear requests
  // a set only counts on an update strobe; the clear mask is the
  // write data itself, one bit per slot
  wire [11:0] level0Set  = {12{slotLevelUpdate}} & slotLevel0Met;
  wire [11:0] level1Set  = {12{slotLevelUpdate}} & slotLevel1Met;
  wire [11:0] level0Clr  = {12{wrLevel0Status}} & regWrData[11:0];
  wire [11:0] level1Clr  = {12{wrLevel1Status}} & regWrData[11:0];

  // level-0 sticky flags
  // set on update when the criterion is met, cleared by writing one
  dier_level_flags uLevel0 (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .setReq (level0Set),
    .clrReq (level0Clr),
    .flag_q (slotLevel0Flag)
  );

  // level-1 sticky flags
  // same behaviour as level-0, fed from its own criterion and clear
  dier_level_flags uLevel1 (
    .clk    (clk),
    .resetn (resetn),
    .ce     (ce),
    .setReq (level1Set),
    .clrReq (level1Clr),
    .flag_q (slotLevel1Flag)
  );

  // enable registers; cleared at reset so nothing reaches a line
  // each write replaces the whole masked word; ce low freezes all
  // four registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // all masks clear, so no source reaches a line
      firstDataFifoEnable_q  <= dier_pkg::RST_ENABLE;
      secondDataFifoEnable_q <= dier_pkg::RST_ENABLE;
      firstLevel0Enable_q    <= dier_pkg::RST_ENABLE;
      firstLevel1Enable_q    <= dier_pkg::RST_ENABLE;
    end else if (ce) begin
      // first line queue and slot data enables
      if (wrFirstData) begin
        firstDataFifoEnable_q <= dataFifoWr;
      end
      // second line queue and slot data enables
      if (wrSecondData) begin
        secondDataFifoEnable_q <= dataFifoWr;
      end
      // first line level-0 enables
      if (wrFirstLevel0) begin
        firstLevel0Enable_q <= levelWr;
      end
      // first line level-1 enables
      if (wrFirstLevel1) begin
        firstLevel1Enable_q <= levelWr;
      end
    end
  end

  // read mux; unmapped offsets read zero
  // status reads show the sticky flags with the upper nibble zero;
  // the enables are read straight from their flops
  wire [15:0] level0StatusRd = {4'h0, slotLevel0Flag};
  wire [15:0] level1StatusRd = {4'h0, slotLevel1Flag};
  wire [15:0] rdMux =
    hitFirstData    ? firstDataFifoEnable_q  :
    hitSecondData   ? secondDataFifoEnable_q :
    hitFirstLevel0  ? firstLevel0Enable_q    :
    hitFirstLevel1  ? firstLevel1Enable_q    :
    hitLevel0Status ? level0StatusRd         :
    hitLevel1Status ? level1StatusRd         :
    dier_pkg::READ_UNMAPPED;

  // read data captured one cycle after the read strobe
  // a write and a read in one cycle return the old value, since the
  // mux looks at the flops before the write lands
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regRdData_q <= dier_pkg::READ_UNMAPPED;
    end else if (ce && regRdEn) begin
      // hold the word until the next taken read
      regRdData_q <= rdMux;
    end
  end

  // second-output queue gates
  // only bits 15:13 and 11:0 of the second data register feed a line
  wire secondThresholdGate =
    secondDataFifoEnable_q[dier_pkg::BIT_QUEUE_THRESHOLD]
    & queueThresholdFlag;
  wire secondUnderflowGate =
    secondDataFifoEnable_q[dier_pkg::BIT_QUEUE_UNDERFLOW]
    & queueUnderflowFlag;
  wire secondOverflowGate =
    secondDataFifoEnable_q[dier_pkg::BIT_QUEUE_OVERFLOW]
    & queueOverflowFlag;
  // second-output slot data gates, bit n for slot n
  // slot A is bit 0 and slot L is bit 11
  wire [11:0] secondSlotDataGate =
    secondDataFifoEnable_q[dier_pkg::SLOT_MSB:0] & slotDataFlag;

  // first-output queue gates
  // the first line uses the same bit layout as the second
  wire firstThresholdGate =
    firstDataFifoEnable_q[dier_pkg::BIT_QUEUE_THRESHOLD]
    & queueThresholdFlag;
  wire firstUnderflowGate =
    firstDataFifoEnable_q[dier_pkg::BIT_QUEUE_UNDERFLOW]
    & queueUnderflowFlag;
  wire firstOverflowGate =
    firstDataFifoEnable_q[dier_pkg::BIT_QUEUE_OVERFLOW]
    & queueOverflowFlag;
  // first-output slot gates
  // data, level-0 and level-1 each have their own twelve-bit mask,
  // so a slot can raise the first line through any of the three
  wire [11:0] firstSlotDataGate =
    firstDataFifoEnable_q[dier_pkg::SLOT_MSB:0] & slotDataFlag;
  wire [11:0] firstSlotLevel0Gate =
    firstLevel0Enable_q[dier_pkg::SLOT_MSB:0] & slotLevel0Flag;
  wire [11:0] firstSlotLevel1Gate =
    firstLevel1Enable_q[dier_pkg::SLOT_MSB:0] & slotLevel1Flag;

  // line requests: OR of every enabled source
  // the second line has no level sources in this block; its level
  // masks live beside the status logic outside
  wire firstIrqReq = firstThresholdGate | firstUnderflowGate
                   | firstOverflowGate | (|firstSlotDataGate)
                   | (|firstSlotLevel0Gate)
                   | (|firstSlotLevel1Gate);
  wire secondIrqReq = secondThresholdGate | secondUnderflowGate
                    | secondOverflowGate
                    | (|secondSlotDataGate);

  // registered interrupt lines, one cycle behind their sources
  // registering keeps glitches of the OR tree off the lines; the cost
  // is one cycle of latency after a source or an enable moves
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      // both lines low while reset is held
      firstIrq_q  <= 1'b0;
      secondIrq_q <= 1'b0;
    end else if (ce) begin
      // follow the requests only while ce is high
      firstIrq_q  <= firstIrqReq;
      secondIrq_q <= secondIrqReq;
    end
  end

  // outputs
  // every output comes straight from a flop
  assign regRdData = regRdData_q;
  assign firstIrq  = firstIrq_q;
  assign secondIrq = secondIrq_q;

endmodule

// ===== verif/dier_top_props.sv
// port-level assertions for the interrupt enable routing block
`timescale 1ns/1ps
module dier_top_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        ce,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic        queueThresholdFlag,
  input wire logic        queueUnderflowFlag,
  input wire logic        queueOverflowFlag,
  input wire logic        slotLevelUpdate,
  input wire logic        firstIrq,
  input wire logic        secondIrq,
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic [15:0] regRdData,
  input wire logic [11:0] slotDataFlag,
  input wire logic [11:0] slotLevel0Met,
  input wire logic [11:0] slotLevel1Met,
  input wire logic [11:0] slotLevel0Flag,
  input wire logic [11:0] slotLevel1Flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // no queue or data source is active
  wire quiet = !(queueThresholdFlag | queueUnderflowFlag |
                 queueOverflowFlag) && slotDataFlag == 12'h000;
  // level flag update and level-0 clear steps
  sequence s_upd; ce && slotLevelUpdate; endsequence
  sequence s_clr0; ce && regWrEn && regAddr == 8'h05 && !slotLevelUpdate;
  endsequence
  a_level_res_zero:
    assert property (ce && regRdEn && regAddr[7:1] == 7'h0b |=>
      regRdData[15:12] == 4'h0) else $error("level reserved bits set");
  a_bit12_zero:
    assert property (ce && regRdEn && regAddr == 8'h15 |=> !regRdData[12])
    else $error("reserved bit 12 set");
  a_level0_set:
    assert property (s_upd |=> (slotLevel0Flag & $past(slotLevel0Met)) ==
      $past(slotLevel0Met)) else $error("level-0 flag not set");
  a_level1_set:
    assert property (s_upd |=> (slotLevel1Flag & $past(slotLevel1Met)) ==
      $past(slotLevel1Met)) else $error("level-1 flag not set");
  a_level1_sticky:
    assert property (ce && !(regWrEn && regAddr == 8'h06) |=>
      $past(slotLevel1Flag) == (slotLevel1Flag & $past(slotLevel1Flag)))
    else $error("level-1 flag dropped");
  a_level0_clear:
    assert property (s_clr0 |=> (slotLevel0Flag & $past(regWrData[11:0]))
      == 12'h000) else $error("level-0 flag not cleared");
  a_second_quiet:
    assert property (ce && quiet |=> !secondIrq)
    else $error("second line without source");
  a_first_quiet:
    assert property (ce && quiet && slotLevel0Flag == 12'h000 &&
      slotLevel1Flag == 12'h000 ##1 1'b1 |-> !firstIrq)
    else $error("first line without source");
  a_reset_quiet:
    assert property ($rose(resetn) |-> !firstIrq && !secondIrq &&
      regRdData == 16'h0000 && slotLevel0Flag == 12'h000)
    else $error("output set after reset");
endmodule
bind dier_top dier_top_props i_props (.clk, .resetn, .ce, .regWrEn,
  .regRdEn, .queueThresholdFlag, .queueUnderflowFlag, .queueOverflowFlag,
  .slotLevelUpdate, .firstIrq, .secondIrq, .regAddr, .regWrData,
  .regRdData, .slotDataFlag, .slotLevel0Met, .slotLevel1Met,
  .slotLevel0Flag, .slotLevel1Flag);

// ===== verif/dier_host_model.sv
// host side model that logs each interrupt line it has seen asserted
`timescale 1ns/1ps
module dier_host_model (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic firstIrq,
  input  wire logic secondIrq,
  output logic      seenFirst,
  output logic      seenSecond
);
  // sticky log, as a polling host would record the two lines
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) {seenFirst, seenSecond} <= 2'b00;
    else {seenFirst, seenSecond} <= {seenFirst, seenSecond} |
                                    {firstIrq, secondIrq};
  end
endmodule

// ===== verif/test_dier_top.sv
// self-checking bench for the interrupt enable routing block
`timescale 1ns/1ps
module test_dier_top;
  typedef struct packed {
    logic [7:0] a; logic [15:0] w, r; logic [14:0] s; logic [1:0] q;
  } dier_row_type;
  // offset, write, readback, sources {th,uf,of,data}, lines {first,second}
  localparam dier_row_type ROWS [11] = '{
    '{8'h15, 16'h8000, 16'h8000, 15'h4000, 2'b01},
    '{8'h15, 16'h4000, 16'h4000, 15'h4000, 2'b00},
    '{8'h15, 16'h4000, 16'h4000, 15'h2000, 2'b01},
    '{8'h15, 16'h3001, 16'h2001, 15'h1000, 2'b01},
    '{8'h15, 16'h0800, 16'h0800, 15'h0800, 2'b01},
    '{8'h15, 16'h0800, 16'h0800, 15'h77ff, 2'b00},
    '{8'h14, 16'h001f, 16'h001f, 15'h0010, 2'b10},
    '{8'h14, 16'hfffe, 16'heffe, 15'h0001, 2'b00},
    '{8'h16, 16'hffff, 16'h0fff, 15'h0000, 2'b00},
    '{8'h17, 16'hf080, 16'h0080, 15'h0000, 2'b00},
    '{8'h30, 16'hffff, 16'h0000, 15'h0000, 2'b00}};
  logic        clk, resetn, ce, regWrEn, regRdEn, slotLevelUpdate;
  logic        queueThresholdFlag, queueUnderflowFlag, queueOverflowFlag;
  logic        firstIrq, secondIrq, seenFirst, seenSecond;
  logic [7:0]  regAddr;
  logic [15:0] regWrData, regRdData;
  logic [11:0] slotDataFlag, slotLevel0Met, slotLevel1Met;
  logic [11:0] slotLevel0Flag, slotLevel1Flag;
  int          miscompares, total_checks;
  dier_top i_dut (.clk, .resetn, .ce, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .queueThresholdFlag, .queueUnderflowFlag,
    .queueOverflowFlag, .slotDataFlag, .slotLevelUpdate, .slotLevel0Met,
    .slotLevel1Met, .slotLevel0Flag, .slotLevel1Flag, .firstIrq,
    .secondIrq);
  dier_host_model i_host (.clk, .resetn, .firstIrq, .secondIrq,
    .seenFirst, .seenSecond);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one strobed access; inputs move 1 ns after the edge, then one idle
  // edge so that no strobe is lowered and raised in one time step
  task automatic acc(input logic [7:0] a, input logic [15:0] d, input bit w);
    regAddr = a;
    regWrData = d;
    regWrEn = w;
    regRdEn = !w;
    @(posedge clk) #1;
    {regWrEn, regRdEn} = 2'b00;
    @(posedge clk) #1;
  endtask
  task automatic stop_test();
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {resetn, regWrEn, regRdEn, slotLevelUpdate, queueThresholdFlag,
     queueUnderflowFlag, queueOverflowFlag, regAddr, regWrData} = '0;
    {slotDataFlag, slotLevel0Met, slotLevel1Met} = '0;
    ce = 1'b1;
    repeat (5) @(posedge clk);
    #1 resetn = 1'b1;
    for (int i = 4; i < 8; i++) begin
      acc(8'(8'h10 + i), 16'h0000, 1'b0);
      check(regRdData, 16'h0000);
    end
    foreach (ROWS[i]) begin
      acc(ROWS[i].a, ROWS[i].w, 1'b1);
      {queueThresholdFlag, queueUnderflowFlag, queueOverflowFlag,
       slotDataFlag} = ROWS[i].s;
      acc(ROWS[i].a, 16'h0000, 1'b0);
      check(regRdData, ROWS[i].r);
      check({14'h0, firstIrq, secondIrq}, {14'h0, ROWS[i].q});
    end
    // level flags: set, clear, set beating a same-cycle clear
    {slotLevel0Met, slotLevelUpdate} = {12'h001, 1'b1};
    @(posedge clk) #1 slotLevelUpdate = 1'b0;
    @(posedge clk) #1;
    check({4'h0, slotLevel0Flag}, 16'h0001);
    check({15'h0, firstIrq}, 16'h0001);
    acc(8'h05, 16'h0000, 1'b0);
    check(regRdData, 16'h0001);
    acc(8'h05, 16'h0001, 1'b1);
    check({4'h0, slotLevel0Flag}, 16'h0000);
    {slotLevel0Met, slotLevel1Met, slotLevelUpdate} = {12'h000, 12'h081, 1'b1};
    acc(8'h06, 16'h0080, 1'b1);
    slotLevelUpdate = 1'b0;
    check({4'h0, slotLevel1Flag}, 16'h0081);
    check({15'h0, firstIrq}, 16'h0001);
    acc(8'h06, 16'h0000, 1'b0);
    check(regRdData, 16'h0081);
    acc(8'h06, 16'h0081, 1'b1);
    check({3'h0, firstIrq, slotLevel1Flag}, 16'h0000);
    check({14'h0, seenFirst, seenSecond}, 16'h0003);
    // mid-run reset with live sources, then a write while ce is low
    {queueThresholdFlag, slotDataFlag} = {1'b1, 12'hfff};
    @(posedge clk) #1;
    check({14'h0, firstIrq, secondIrq}, 16'h0003);
    resetn = 1'b0;
    @(posedge clk) #1 resetn = 1'b1;
    check({14'h0, firstIrq, secondIrq}, 16'h0000);
    ce = 1'b0;
    acc(8'h15, 16'hffff, 1'b1);
    ce = 1'b1;
    for (int i = 4; i < 8; i++) begin
      acc(8'(8'h10 + i), 16'h0000, 1'b0);
      check(regRdData, 16'h0000);
    end
    check({14'h0, firstIrq, secondIrq}, 16'h0000);
    stop_test();
  end
endmodule
